//--- hw/bes_pkg.sv
package bes_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL        = 8'h00;
    localparam logic [7:0] OFS_STATUS      = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT    = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h0C;
    localparam logic [7:0] OFS_BITS_LO     = 8'h10;
    localparam logic [7:0] OFS_BITS_HI     = 8'h14;
    localparam logic [7:0] OFS_ERR_TOTAL   = 8'h18;
    localparam logic [7:0] OFS_ONE_AS_ZERO = 8'h1C;
    localparam logic [7:0] OFS_ZERO_AS_ONE = 8'h20;
    localparam logic [7:0] OFS_ERR_DELTA   = 8'h24;
    localparam logic [7:0] OFS_EFREE_BASE  = 8'h28;
    localparam logic [7:0] OFS_ERRD_BASE   = 8'h38;
    localparam logic [7:0] OFS_SKIP_SET    = 8'h48;
    localparam logic [7:0] OFS_RESYNC      = 8'h4C;
    localparam logic [7:0] OFS_BAD_BURST   = 8'h50;
    localparam logic [7:0] OFS_TOTAL_BURST = 8'h54;
    localparam logic [7:0] OFS_SYNC_RATIO  = 8'h58;
    localparam logic [7:0] OFS_DUTY_RESULT = 8'h5C;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_ACCUM_BIT = 0;
    localparam int CTRL_BURST_BIT = 1;
    localparam int CTRL_MEMPAT_BIT = 2;
    localparam int CTRL_START_BIT = 3;

    localparam logic [31:0] NAN_CODE   = 32'hFFFF_FFFF;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ  = 250;
    localparam int MS_US    = 1000;
    localparam int MS_CYCLES = MS_US * CLK_MHZ;
    localparam int N_GRAINS = 4;
    localparam logic [32:0] GATE_LIMIT_BITS = 33'h1_0000_0000;

    typedef enum logic [1:0] {
        BES_NO_ERROR  = 2'b00,
        BES_GATE_LONG = 2'b01,
        BES_NO_DETECT = 2'b10,
        BES_UNKNOWN   = 2'b11
    } bes_burst_e;

endpackage : bes_pkg

//--- hw/bes_stats.sv
`timescale 1ns/1ps
module bes_stats
    import bes_pkg::*;
#(
    parameter int MS_TICKS = MS_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        rx_valid,
    input  wire logic        rx_bit,
    input  wire logic        exp_bit,
    input  wire logic        skip_set_seen,
    input  wire logic        resync_seen,
    input  wire logic        gate_in,
    input  wire logic        burst_synced,
    input  wire logic        detect_word_ok
);

    // Timebase needs at least two cycles per millisecond
    if (MS_TICKS < 2) begin : g_bad_ms_ticks
        $error("MS_TICKS too small");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] gate_sync_reg;
    logic [1:0] det_sync_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_sync_reg <= 3'b000;
            det_sync_reg  <= 2'b00;
        end else begin
            gate_sync_reg <= {gate_sync_reg[1:0], gate_in};
            det_sync_reg  <= {det_sync_reg[0], detect_word_ok};
        end
    end

    wire gate_s    = gate_sync_reg[1];
    wire gate_rise = gate_sync_reg[1] & ~gate_sync_reg[2];
    wire det_ok_s  = det_sync_reg[1];

    // ------------------------------------------------------------
    // Control register and APB
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [1:0]  irq_stat_reg;
    logic [1:0]  irq_mask_reg;
    logic        start_pulse_reg;

    wire wr_acc = psel & penable & pwrite;
    wire accum_on = ctrl_reg[CTRL_ACCUM_BIT];
    wire burst_on = ctrl_reg[CTRL_BURST_BIT];
    wire mem_pat  = ctrl_reg[CTRL_MEMPAT_BIT];
    wire start    = start_pulse_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg        <= CTRL_RESET;
            start_pulse_reg <= 1'b0;
        end else begin
            start_pulse_reg <= wr_acc && paddr == OFS_CTRL && pwdata[CTRL_START_BIT];
            if (wr_acc && paddr == OFS_CTRL) begin
                ctrl_reg <= {29'h0000_0000, pwdata[2:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Bit comparison
    // ------------------------------------------------------------
    wire one_as_zero = rx_valid & exp_bit & ~rx_bit;
    wire zero_as_one = rx_valid & ~exp_bit & rx_bit;
    wire bit_err     = one_as_zero | zero_as_one;
    wire acc_bit     = accum_on & rx_valid;

    logic [63:0] bit_count_reg;
    logic [31:0] error_total_count;
    logic [31:0] one_as_zero_count;
    logic [31:0] zero_as_one_count;
    logic [31:0] expected_skip_set_count;
    logic [31:0] auto_resync_count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_count_reg           <= 64'h0;
            error_total_count       <= 32'h0;
            one_as_zero_count       <= 32'h0;
            zero_as_one_count       <= 32'h0;
            expected_skip_set_count <= 32'h0;
            auto_resync_count       <= 32'h0;
        end else if (start) begin
            bit_count_reg           <= 64'h0;
            error_total_count       <= 32'h0;
            one_as_zero_count       <= 32'h0;
            zero_as_one_count       <= 32'h0;
            expected_skip_set_count <= 32'h0;
            auto_resync_count       <= 32'h0;
        end else if (accum_on) begin
            if (rx_valid) bit_count_reg <= bit_count_reg + 64'h1;
            if (bit_err) error_total_count <= error_total_count + 32'h1;
            if (one_as_zero) one_as_zero_count <= one_as_zero_count + 32'h1;
            if (zero_as_one) zero_as_one_count <= zero_as_one_count + 32'h1;
            if (skip_set_seen) begin
                expected_skip_set_count <= expected_skip_set_count + 32'h1;
            end
            if (resync_seen) auto_resync_count <= auto_resync_count + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Interval timebase: 1 ms, 10 ms, 100 ms, 1 s
    // ------------------------------------------------------------
    logic [31:0] ms_cnt_reg;
    logic [3:0]  dec_cnt_reg [1:N_GRAINS-1];
    logic [N_GRAINS-1:0] tick;           // 0:ms 1:10ms 2:100ms 3:s

    assign tick[0] = (ms_cnt_reg == 32'(MS_TICKS - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_reg <= 32'h0;
        end else if (start || tick[0]) begin
            ms_cnt_reg <= 32'h0;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 32'h1;
        end
    end

    logic [31:0] error_free_intervals [N_GRAINS];
    logic [31:0] errored_intervals    [N_GRAINS];
    logic [N_GRAINS-1:0] seen_err_reg;

    genvar g;
    generate
        for (g = 0; g < N_GRAINS; g++) begin : g_grain
            if (g > 0) begin : g_div
                assign tick[g] = tick[g-1] && dec_cnt_reg[g] == 4'd9;
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        dec_cnt_reg[g] <= 4'd0;
                    end else if (start) begin
                        dec_cnt_reg[g] <= 4'd0;
                    end else if (tick[g-1]) begin
                        dec_cnt_reg[g] <= tick[g] ? 4'd0 : dec_cnt_reg[g] + 4'd1;
                    end
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    seen_err_reg[g]         <= 1'b0;
                    error_free_intervals[g] <= 32'h0;
                    errored_intervals[g]    <= 32'h0;
                end else if (start) begin
                    seen_err_reg[g]         <= 1'b0;
                    error_free_intervals[g] <= 32'h0;
                    errored_intervals[g]    <= 32'h0;
                end else if (tick[g]) begin
                    seen_err_reg[g] <= 1'b0;
                    if (accum_on) begin
                        if (seen_err_reg[g] || bit_err) begin
                            errored_intervals[g] <= errored_intervals[g] + 32'h1;
                        end else begin
                            error_free_intervals[g] <= error_free_intervals[g] + 32'h1;
                        end
                    end
                end else if (bit_err) begin
                    seen_err_reg[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Tenth-second delta count, free of accumulation
    // ------------------------------------------------------------
    logic [31:0] delta_run_reg;
    logic [31:0] delta_count_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delta_run_reg   <= 32'h0;
            delta_count_reg <= 32'h0;
        end else if (tick[2]) begin
            delta_count_reg <= delta_run_reg + {31'h0, bit_err};
            delta_run_reg   <= 32'h0;
        end else if (bit_err) begin
            delta_run_reg <= delta_run_reg + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Burst statistics and state
    // ------------------------------------------------------------
    logic [31:0] bad_burst_count;
    logic [31:0] total_burst_count;
    logic [32:0] gate_bits_reg;
    logic        burst_err_reg;
    logic        gate_long_reg;
    logic        no_detect_reg;
    logic        started_reg;

    // Conditions judged inside the open gate window
    wire gate_long_now = gate_bits_reg > GATE_LIMIT_BITS;
    wire no_detect_now = mem_pat & ~det_ok_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_bits_reg <= 33'h0;
            burst_err_reg <= 1'b0;
        end else if (!gate_s || start) begin
            gate_bits_reg <= 33'h0;
            burst_err_reg <= 1'b0;
        end else begin
            // Stop one past the limit so the overflow stays visible
            if (rx_valid && !gate_long_now) gate_bits_reg <= gate_bits_reg + 33'h1;
            if (bit_err) burst_err_reg <= 1'b1;
        end
    end

    wire gate_fall = gate_sync_reg[2] & ~gate_sync_reg[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bad_burst_count   <= 32'h0;
            total_burst_count <= 32'h0;
            gate_long_reg     <= 1'b0;
            no_detect_reg     <= 1'b0;
            started_reg       <= 1'b0;
        end else if (start) begin
            bad_burst_count   <= 32'h0;
            total_burst_count <= 32'h0;
            gate_long_reg     <= 1'b0;
            no_detect_reg     <= 1'b0;
            started_reg       <= 1'b1;
        end else if (accum_on && burst_on) begin
            if (gate_rise) total_burst_count <= total_burst_count + 32'h1;
            if (gate_fall && burst_err_reg) bad_burst_count <= bad_burst_count + 32'h1;
            if (gate_long_now) gate_long_reg <= 1'b1;
            if (no_detect_now && gate_s) no_detect_reg <= 1'b1;
        end
    end

    bes_burst_e burst_state;
    always_comb begin
        if (!started_reg || !accum_on || !burst_on) begin
            burst_state = BES_UNKNOWN;
        end else if (gate_long_reg) begin
            burst_state = BES_GATE_LONG;
        end else if (no_detect_reg) begin
            burst_state = BES_NO_DETECT;
        end else begin
            burst_state = BES_NO_ERROR;
        end
    end

    // Sync ratio: good bursts per total, 16.16 fixed point
    logic [31:0] sync_ratio;
    always_comb begin
        if (total_burst_count == 32'h0) begin
            sync_ratio = 32'h0;
        end else begin
            sync_ratio = 32'({(total_burst_count - bad_burst_count), 16'h0000}
                             / {16'h0000, total_burst_count});
        end
    end

    // ------------------------------------------------------------
    // Interrupts: 0 burst error latched, 1 errored second
    // ------------------------------------------------------------
    wire [1:0] irq_ev = {tick[3] & (seen_err_reg[3] | bit_err) & accum_on,
                         burst_on & (gate_long_now | (no_detect_now & gate_s))};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= 2'b00;
            irq_mask_reg <= 2'b00;
            irq          <= 1'b0;
        end else begin
            if (wr_acc && paddr == OFS_IRQ_MASK) irq_mask_reg <= pwdata[1:0];
            if (wr_acc && paddr == OFS_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~pwdata[1:0]) | irq_ev;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_ev;
            end
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // APB read
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0;
        case (paddr)
            OFS_CTRL:        rd_mux = ctrl_reg;
            OFS_STATUS:      rd_mux = {29'h0, started_reg, burst_state};
            OFS_IRQ_STAT:    rd_mux = {30'h0, irq_stat_reg};
            OFS_IRQ_MASK:    rd_mux = {30'h0, irq_mask_reg};
            OFS_BITS_LO:     rd_mux = bit_count_reg[31:0];
            OFS_BITS_HI:     rd_mux = bit_count_reg[63:32];
            OFS_ERR_TOTAL:   rd_mux = error_total_count;
            OFS_ONE_AS_ZERO: rd_mux = one_as_zero_count;
            OFS_ZERO_AS_ONE: rd_mux = zero_as_one_count;
            OFS_ERR_DELTA:   rd_mux = delta_count_reg;
            OFS_SKIP_SET:    rd_mux = expected_skip_set_count;
            OFS_RESYNC:      rd_mux = auto_resync_count;
            OFS_BAD_BURST:   rd_mux = burst_on ? bad_burst_count : NAN_CODE;
            OFS_TOTAL_BURST: rd_mux = burst_on ? total_burst_count : NAN_CODE;
            OFS_SYNC_RATIO:  rd_mux = burst_on ? sync_ratio : NAN_CODE;
            OFS_DUTY_RESULT: rd_mux = NAN_CODE;
            default: begin
                if (paddr >= OFS_EFREE_BASE && paddr < OFS_ERRD_BASE
                    && paddr[1:0] == 2'b00) begin
                    rd_mux = error_free_intervals[2'(3 - paddr[3:2] + 2)];
                end else if (paddr >= OFS_ERRD_BASE && paddr < OFS_SKIP_SET
                    && paddr[1:0] == 2'b00) begin
                    // Both banks hold s, 100 ms, 10 ms, 1 ms in address order
                    rd_mux = errored_intervals[2'(3 - paddr[3:2] + 2)];
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    // Zero wait: pready answers in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~rd_hit;
            if (psel && !penable && !pwrite) prdata <= rd_mux;
        end
    end

endmodule : bes_stats

//--- tb/bes_src_model.sv
`timescale 1ns/1ps
module bes_src_model (
    input  wire logic pclk,
    output logic      rx_valid,
    output logic      rx_bit,
    output logic      exp_bit,
    output logic      skip_set_seen,
    output logic      resync_seen,
    output logic      gate_in,
    output logic      detect_word_ok
);
    initial begin
        {rx_valid, rx_bit, exp_bit, skip_set_seen, resync_seen, gate_in} = '0;
        detect_word_ok = 1'b1;
    end
    // ------------------------------------------------------------
    // Stream drivers
    // ------------------------------------------------------------
    task automatic bits(input logic [7:0] e, input logic [7:0] r, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            @(posedge pclk);
            rx_valid <= 1'b1;
            exp_bit  <= e[i];
            rx_bit   <= r[i];
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        // Idle lines toggle so stale data is never reused
        rx_bit   <= ~r[8-n];
        exp_bit  <= ~e[8-n];
    endtask : bits
    task automatic events(input int ns, input int nr);
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            skip_set_seen <= (i < ns);
            resync_seen   <= (i < nr);
            @(posedge pclk);
            skip_set_seen <= 1'b0;
            resync_seen   <= 1'b0;
        end
    endtask : events
    task automatic burst(input logic [7:0] e, input logic [7:0] r, input int n);
        @(posedge pclk);
        gate_in <= 1'b1;
        repeat (4) @(posedge pclk);
        bits(e, r, n);
        repeat (4) @(posedge pclk);
        gate_in <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask : burst
    task automatic set_det(input logic d);
        @(posedge pclk);
        detect_word_ok <= d;
    endtask : set_det
endmodule : bes_src_model

//--- tb/bes_stats_checker.sv
`timescale 1ns/1ps
module bes_stats_checker
    import bes_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // Bus and result checks
    // ------------------------------------------------------------
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_idle_quiet: assert property (!psel |-> !pready && !pslverr)
        else $error("answer without select");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_unmapped: assert property (pready && paddr > OFS_DUTY_RESULT |-> pslverr)
        else $error("unmapped address accepted");
    a_map_no_err: assert property (pready && paddr <= OFS_DUTY_RESULT && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("mapped address refused");
    a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_duty_nan: assert property (pready && !pwrite && paddr == OFS_DUTY_RESULT |->
        prdata == NAN_CODE) else $error("duty result not NaN");
    a_rdata_hold: assert property (!$stable(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("prdata changed without read");
    a_irq_fall_write: assert property ($fell(irq) |->
        $past(wr_acc, 1) || $past(wr_acc, 2) || $past(wr_acc, 3))
        else $error("irq fell without write");
endmodule : bes_stats_checker

bind bes_stats bes_stats_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq)
);

//--- tb/tb.sv
`timescale 1ns/1ps
module tb
    import bes_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e_flag;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, v;
    logic        rx_valid, rx_bit, exp_bit, skip_set_seen, resync_seen, gate_in, det_ok;
    int          num_errors, num_checks;

    bes_stats #(.MS_TICKS(4)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .rx_valid(rx_valid), .rx_bit(rx_bit), .exp_bit(exp_bit),
        .skip_set_seen(skip_set_seen), .resync_seen(resync_seen), .gate_in(gate_in),
        .burst_synced(1'b1), .detect_word_ok(det_ok));
    bes_src_model u_src (
        .pclk(pclk), .rx_valid(rx_valid), .rx_bit(rx_bit), .exp_bit(exp_bit),
        .skip_set_seen(skip_set_seen), .resync_seen(resync_seen), .gate_in(gate_in),
        .detect_word_ok(det_ok));
    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        v       = prdata;
        e_flag  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(v, exp);
    endtask : rc
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : w
    task end_sim;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rc(OFS_CTRL, CTRL_RESET);
        rc(OFS_STATUS, 32'h0000_0003);
        rc(OFS_DUTY_RESULT, NAN_CODE);
        rc(OFS_BAD_BURST, NAN_CODE);
        rc(8'h60, 32'h0000_0000);
        chk({31'b0, e_flag}, 32'h0000_0001);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_delta;
        u_src.bits(8'hE0, 8'h00, 3);
        v = '0;
        for (int i = 0; i < 400 && v == 0; i++) bus(1'b0, OFS_ERR_DELTA, 32'h0000_0000);
        chk(v, 32'h0000_0003);
        rc(OFS_ERR_TOTAL, 32'h0000_0000);
        $display("t_delta done");
    endtask : t_delta
    task automatic t_count;
        w(OFS_CTRL, 32'h0000_0009);
        u_src.bits(8'hF0, 8'h3C, 8);
        u_src.events(3, 2);
        rc(OFS_BITS_LO, 32'h0000_0008);
        rc(OFS_ERR_TOTAL, 32'h0000_0004);
        rc(OFS_ONE_AS_ZERO, 32'h0000_0002);
        rc(OFS_ZERO_AS_ONE, 32'h0000_0002);
        rc(OFS_SKIP_SET, 32'h0000_0003);
        rc(OFS_RESYNC, 32'h0000_0002);
        w(OFS_ERR_TOTAL, 32'h0000_0005);
        rc(OFS_ERR_TOTAL, 32'h0000_0004);
        w(OFS_CTRL, 32'h0000_0009);
        rc(OFS_BITS_LO, 32'h0000_0000);
        rc(OFS_ONE_AS_ZERO, 32'h0000_0000);
        rc(OFS_RESYNC, 32'h0000_0000);
        $display("t_count done");
    endtask : t_count
    task automatic t_interval;
        logic [31:0] fr [3] = '{32'h0000_0000, 32'h0000_0009, 32'h0000_0063};
        logic [31:0] er [4] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 32'h0000_0002};
        w(OFS_IRQ_MASK, 32'h0000_0000);
        w(OFS_CTRL, 32'h0000_0009);
        repeat (2000) @(posedge pclk);
        // Two errors four cycles apart: two errored ms, one errored 10 ms
        u_src.bits(8'h88, 8'h00, 5);
        repeat (2016) @(posedge pclk);
        w(OFS_CTRL, 32'h0000_0000);
        chk({31'b0, irq}, 32'h0000_0000);
        rc(OFS_IRQ_STAT, 32'h0000_0002);
        for (int i = 0; i < 3; i++) rc(OFS_EFREE_BASE + 8'(4 * i), fr[i]);
        for (int i = 0; i < 4; i++) rc(OFS_ERRD_BASE + 8'(4 * i), er[i]);
        bus(1'b0, OFS_EFREE_BASE + 8'h0C, 32'h0000_0000);
        chk(v, 32'h0000_03EC);
        w(OFS_IRQ_MASK, 32'h0000_0002);
        repeat (3) @(posedge pclk);
        chk({31'b0, irq}, 32'h0000_0001);
        w(OFS_IRQ_STAT, 32'h0000_0002);
        repeat (3) @(posedge pclk);
        chk({31'b0, irq}, 32'h0000_0000);
        rc(OFS_IRQ_STAT, 32'h0000_0000);
        $display("t_interval done");
    endtask : t_interval
    task automatic t_burst;
        w(OFS_CTRL, 32'h0000_000F);
        u_src.burst(8'hFF, 8'hFF, 8);
        u_src.burst(8'h80, 8'h00, 2);
        rc(OFS_TOTAL_BURST, 32'h0000_0002);
        rc(OFS_BAD_BURST, 32'h0000_0001);
        rc(OFS_SYNC_RATIO, 32'h0000_8000);
        rc(OFS_STATUS, 32'h0000_0004);
        u_src.set_det(1'b0);
        u_src.burst(8'hFF, 8'hFF, 1);
        u_src.set_det(1'b1);
        u_src.burst(8'hFF, 8'hFF, 1);
        rc(OFS_STATUS, 32'h0000_0006);
        rc(OFS_IRQ_STAT, 32'h0000_0001);
        w(OFS_CTRL, 32'h0000_000F);
        rc(OFS_STATUS, 32'h0000_0004);
        rc(OFS_BAD_BURST, 32'h0000_0000);
        w(OFS_CTRL, 32'h0000_000B);
        u_src.set_det(1'b0);
        u_src.burst(8'hFF, 8'hFF, 1);
        rc(OFS_STATUS, 32'h0000_0004);
        w(OFS_CTRL, 32'h0000_0001);
        rc(OFS_STATUS, 32'h0000_0007);
        rc(OFS_TOTAL_BURST, NAN_CODE);
        $display("t_burst done");
    endtask : t_burst
    // ------------------------------------------------------------
    // Clock, reset, sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        num_errors = 0;
        num_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_delta();
        t_count();
        t_interval();
        t_burst();
        end_sim();
    end
    initial begin
        repeat (30000) @(posedge pclk);
        num_errors++;
        end_sim();
    end
endmodule : tb
